// >>> hdl/sfsg_regs.svh
// register offsets, field positions and reset values of the section guard
`ifndef SFSG_REGS_SVH
`define SFSG_REGS_SVH

// ==========================================================
// address map
`define SFSG_APB_AW 12
`define SFSG_OFF_CTRL 12'h000
`define SFSG_OFF_LOCK 12'h004
`define SFSG_OFF_GEOM 12'h008

// ==========================================================
// fields
`define SFSG_CTRL_REENABLE 0
`define SFSG_STAT_BUSY 0
`define SFSG_STAT_ACTIVE 1
`define SFSG_STAT_STALL 2
`define SFSG_LOCK_W 4
`define SFSG_LOCK_RESET 4'hF
`define SFSG_LOCK_ALL1 4'hF
`define SFSG_LOCK_APP_LOW 0
`define SFSG_LOCK_APP_HIGH 1
`define SFSG_LOCK_BOOT_LOW 2
`define SFSG_LOCK_BOOT_HIGH 3
`define SFSG_GEOM_FUSE_LSB 0
`define SFSG_GEOM_START_LSB 16

// ==========================================================
// geometry
`define SFSG_FLASH_AW 13
`define SFSG_FLASH_WORDS 14'h2000
`define SFSG_TARGET_RESET 13'h0000

`endif

// >>> hdl/sfsg_pkg.sv
// types shared by the section guard and its users
package sfsg_pkg;

`include "sfsg_regs.svh"

   // ==========================================================
   // program-store operations
   typedef enum logic [1:0] {
      SFSG_OP_LOAD = 2'h0,
      SFSG_OP_ERASE = 2'h1,
      SFSG_OP_WRITE = 2'h2,
      SFSG_OP_NONE = 2'h3
   } sfsg_op_e;

   typedef logic [`SFSG_FLASH_AW-1:0] sfsg_addr_t;

   typedef struct packed {
      logic valid;
      sfsg_op_e op;
      sfsg_addr_t pc;
      sfsg_addr_t target;
   } sfsg_pst_s;

   // ==========================================================
   // operation state
   typedef enum logic [2:0] {
      SFSG_IDLE = 3'b001,
      SFSG_RUN_CONC = 3'b010,
      SFSG_RUN_HALT = 3'b100
   } sfsg_state_e;

endpackage : sfsg_pkg

// >>> hdl/sfsg_guard.sv
// selfprog flash section guard: lock bits, section decode, busy handling
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns

module sfsg_guard
   import sfsg_pkg::*;
#(
   parameter int PAGE_W = 6,
   parameter sfsg_addr_t HALT_START = 13'h1C00,
   parameter logic [`SFSG_FLASH_AW:0] BOOT_MIN_WORDS = 14'h0080
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SFSG_APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] boot_size_fuses,
   input wire logic vectors_in_boot,
   input wire sfsg_pst_s pst,
   output logic pst_accept,
   output logic pst_refuse,
   output logic flash_start,
   output sfsg_op_e flash_op,
   output sfsg_addr_t flash_target,
   input wire logic flash_done,
   output logic cpu_stall,
   input wire sfsg_addr_t exec_pc,
   output logic fetch_block,
   output logic irq_disable,
   input wire sfsg_addr_t lpm_pc,
   input wire sfsg_addr_t lpm_addr,
   output logic lpm_allow,
   input wire logic prog_lock_we,
   input wire logic [`SFSG_LOCK_W-1:0] prog_lock_data,
   input wire logic chip_erase
);

   localparam int AW = `SFSG_FLASH_AW;
   localparam logic [AW:0] FLASH_WORDS = `SFSG_FLASH_WORDS;

   // ==========================================================
   // section geometry
   // fuse value 2'b11 gives the smallest boot section
   logic [AW:0] boot_words;
   logic [AW:0] boot_start_raw;
   sfsg_addr_t boot_start;
   assign boot_words = BOOT_MIN_WORDS << (~boot_size_fuses);
   assign boot_start_raw = FLASH_WORDS - boot_words;
   // a fuse/parameter clash must never put boot code in the concurrent part
   // the clamp costs one compare but keeps boot code out of the concurrent part
   assign boot_start = (boot_start_raw[AW-1:0] < HALT_START) ?
      HALT_START : boot_start_raw[AW-1:0];

   function automatic logic in_boot(input sfsg_addr_t a, input sfsg_addr_t s);
      in_boot = (a >= s);
   endfunction : in_boot

   function automatic logic in_halt(input sfsg_addr_t a);
      in_halt = (a[AW-1:PAGE_W] >= HALT_START[AW-1:PAGE_W]);
   endfunction : in_halt

   // ==========================================================
   // state
   logic [`SFSG_LOCK_W-1:0] lock_reg;
   logic [`SFSG_LOCK_W-1:0] lock_next;
   logic busy_reg;
   logic busy_next;
   sfsg_state_e state_reg;
   sfsg_state_e state_next;
   sfsg_addr_t target_reg;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic accept_reg;
   logic refuse_reg;
   logic start_reg;
   sfsg_op_e op_reg;

   // ==========================================================
   // programming pins
   // chip erase and the pin-side lock write come from the serial or
   // parallel programming port, which does not run on pclk; every bit
   // passes three flops and a new level counts only once the second
   // and third flops agree, so a one-cycle glitch never reaches the locks
   // limitation: each bit is filtered on its own, so the lock data must
   // be steady on the pins before the write strobe rises and after it falls
   localparam int PIN_W = `SFSG_LOCK_W + 2;
   localparam int PIN_ERASE = `SFSG_LOCK_W + 1;
   localparam int PIN_WE = `SFSG_LOCK_W;
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s1_reg;
   logic [PIN_W-1:0] pin_s2_reg;
   logic [PIN_W-1:0] pin_s3_reg;
   logic [PIN_W-1:0] pin_filt_reg;
   assign pin_raw = {chip_erase, prog_lock_we, prog_lock_data};

   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_pin_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_s1_reg[gi] <= 1'b0;
               pin_s2_reg[gi] <= 1'b0;
               pin_s3_reg[gi] <= 1'b0;
               pin_filt_reg[gi] <= 1'b0;
            end else begin
               pin_s1_reg[gi] <= pin_raw[gi];
               pin_s2_reg[gi] <= pin_s1_reg[gi];
               pin_s3_reg[gi] <= pin_s2_reg[gi];
               if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
                  pin_filt_reg[gi] <= pin_s3_reg[gi];
               end
            end
         end
      end
   endgenerate

   wire pin_erase = pin_filt_reg[PIN_ERASE];
   wire pin_lock_we = pin_filt_reg[PIN_WE];
   wire [`SFSG_LOCK_W-1:0] pin_lock_data = pin_filt_reg[`SFSG_LOCK_W-1:0];

   // ==========================================================
   // lock decode; zero means programmed
   // pair (high, low): 11 free, 10 no store, 00 no store and no cross load,
   // 01 no cross load; both pairs read the same way for their own section
   wire app_lock_low = lock_reg[`SFSG_LOCK_APP_LOW];
   wire app_lock_high = lock_reg[`SFSG_LOCK_APP_HIGH];
   wire boot_lock_low = lock_reg[`SFSG_LOCK_BOOT_LOW];
   wire boot_lock_high = lock_reg[`SFSG_LOCK_BOOT_HIGH];
   // modes 2 and 3 have the low bit programmed, 3 and 4 the high bit
   wire app_wr_lock = ~app_lock_low;
   wire app_rd_lock = ~app_lock_high;
   wire boot_wr_lock = ~boot_lock_low;
   wire boot_rd_lock = ~boot_lock_high;

   // ==========================================================
   // apb decode
   wire sel_ctrl = (paddr == `SFSG_OFF_CTRL);
   wire sel_lock = (paddr == `SFSG_OFF_LOCK);
   wire sel_geom = (paddr == `SFSG_OFF_GEOM);
   wire mapped = sel_ctrl | sel_lock | sel_geom;
   wire setup_rd = psel & ~penable & ~pwrite;
   wire acc_wr = psel & penable & pwrite & mapped;
   wire wr_ctrl = acc_wr & sel_ctrl;
   wire wr_lock = acc_wr & sel_lock;

   // no wait states: every transfer ends in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   wire idle = (state_reg == SFSG_IDLE);

   // read data is sampled in the setup cycle so it leaves a flop
   always_comb begin
      prdata_next = 32'h0000_0000;
      if (sel_ctrl) begin
         prdata_next[`SFSG_STAT_BUSY] = busy_reg;
         prdata_next[`SFSG_STAT_ACTIVE] = ~idle;
         prdata_next[`SFSG_STAT_STALL] = (state_reg == SFSG_RUN_HALT);
      end else if (sel_lock) begin
         prdata_next[`SFSG_LOCK_W-1:0] = lock_reg;
      end else if (sel_geom) begin
         prdata_next[`SFSG_GEOM_FUSE_LSB+:2] = boot_size_fuses;
         prdata_next[`SFSG_GEOM_START_LSB+:AW] = boot_start;
      end
   end

   // ==========================================================
   // lock bits: writes can only program (clear) bits
   wire [`SFSG_LOCK_W-1:0] sw_mask =
      wr_lock ? pwdata[`SFSG_LOCK_W-1:0] : `SFSG_LOCK_ALL1;
   wire [`SFSG_LOCK_W-1:0] pin_mask =
      pin_lock_we ? pin_lock_data : `SFSG_LOCK_ALL1;
   // only chip erase or presetn can return a programmed bit to one
   always_comb begin
      lock_next = lock_reg & sw_mask & pin_mask;
      if (pin_erase) begin
         lock_next = `SFSG_LOCK_RESET;
      end
   end

   // ==========================================================
   // program-store admission
   wire pc_boot = in_boot(pst.pc, boot_start);
   wire tgt_boot = in_boot(pst.target, boot_start);
   wire op_erase = (pst.op == SFSG_OP_ERASE);
   wire op_write = (pst.op == SFSG_OP_WRITE);
   wire op_prog = op_erase | op_write;
   wire op_load = (pst.op == SFSG_OP_LOAD);
   // any page may be aimed at; only the lock of its own section counts
   wire tgt_locked = tgt_boot ? boot_wr_lock : app_wr_lock;
   // the general memory lock is deliberately not an input here
   // a load needs idle too: a running erase or write owns the page buffer
   wire pst_go = pst.valid & pc_boot & idle & (op_prog | op_load)
      & ~(op_prog & tgt_locked);
   wire pst_no = pst.valid & ~pst_go;

   // ==========================================================
   // operation sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SFSG_IDLE: begin
            // a load changes no operation state: it fills the page buffer and clears the busy flag
            if (pst_go & op_prog) begin
               if (in_halt(pst.target)) begin
                  state_next = SFSG_RUN_HALT;
               end else begin
                  state_next = SFSG_RUN_CONC;
               end
            end
         end
         SFSG_RUN_CONC: begin
            if (flash_done) begin
               state_next = SFSG_IDLE;
            end
         end
         SFSG_RUN_HALT: begin
            if (flash_done) begin
               state_next = SFSG_IDLE;
            end
         end
         default: begin
            state_next = SFSG_IDLE;
         end
      endcase
   end

   // ==========================================================
   // section busy flag; a new start wins over a clear
   // a start in the same cycle as a clear must fence the section again,
   // otherwise concurrent code could run while its page is being changed
   wire busy_set = pst_go & op_prog;
   wire reenable = wr_ctrl & pwdata[`SFSG_CTRL_REENABLE] & idle;
   wire busy_clr = reenable | (pst_go & op_load);
   assign busy_next = busy_set | (busy_reg & ~busy_clr);

   // ==========================================================
   // flops; one register to a block keeps every reset list short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_reg <= `SFSG_LOCK_RESET;
      end else begin
         lock_reg <= lock_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SFSG_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // the page is latched at start so the core may reuse its pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target_reg <= `SFSG_TARGET_RESET;
      end else if (pst_go) begin
         target_reg <= pst.target;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_reg <= SFSG_OP_NONE;
      end else if (pst_go) begin
         op_reg <= pst.op;
      end
   end

   // answers leave flops: the core sees them one cycle after its request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accept_reg <= 1'b0;
      end else begin
         accept_reg <= pst_go;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refuse_reg <= 1'b0;
      end else begin
         refuse_reg <= pst_no;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_reg <= 1'b0;
      end else begin
         start_reg <= pst_go;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;
   assign pst_accept = accept_reg;
   assign pst_refuse = refuse_reg;
   assign flash_start = start_reg;
   assign flash_op = op_reg;
   assign flash_target = target_reg;

   // ==========================================================
   // cpu side gates
   // the stall follows the page latched at start, not the running code
   assign cpu_stall = (state_reg == SFSG_RUN_HALT);

   // concurrent code stays fenced until software re-enables it or an accepted load clears the busy flag
   // halting code is never fenced here; while it is written the core stalls
   wire exec_conc = ~in_halt(exec_pc);
   assign fetch_block = busy_reg & exec_conc;

   wire exec_boot = in_boot(exec_pc, boot_start);
   assign irq_disable = (app_rd_lock & vectors_in_boot & ~exec_boot)
      | (boot_rd_lock & ~vectors_in_boot & exec_boot);

   // ==========================================================
   // program-load admission
   wire lpm_src_boot = in_boot(lpm_pc, boot_start);
   wire lpm_dst_boot = in_boot(lpm_addr, boot_start);
   wire lpm_cross_app = lpm_src_boot & ~lpm_dst_boot & app_rd_lock;
   wire lpm_cross_boot = ~lpm_src_boot & lpm_dst_boot & boot_rd_lock;
   wire lpm_conc_busy = busy_reg & ~in_halt(lpm_addr);
   // loads inside one section are never limited by the locks
   // a halted core fetches nothing, so no load goes through either
   assign lpm_allow = ~(lpm_cross_app | lpm_cross_boot | lpm_conc_busy)
      & ~cpu_stall;

endmodule : sfsg_guard

// >>> bench/sfsg_guard_assertions.sv
// port-level checker of the section guard
`timescale 1ns/1ns
// ==========================================================
// checker
module sfsg_guard_chk
   import sfsg_pkg::*;
#(
   parameter sfsg_addr_t HALT_START = 13'h1C00,
   parameter logic [13:0] BOOT_MIN_WORDS = 14'h0080
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] boot_size_fuses,
   input wire sfsg_pst_s pst,
   input wire logic pst_accept,
   input wire logic pst_refuse,
   input wire logic flash_start,
   input wire sfsg_op_e flash_op,
   input wire sfsg_addr_t flash_target,
   input wire logic flash_done,
   input wire logic cpu_stall,
   input wire sfsg_addr_t exec_pc,
   input wire logic fetch_block,
   input wire logic lpm_allow
);
   logic [13:0] bstart;
   assign bstart = 14'h2000 - (BOOT_MIN_WORDS << (2'h3 - boot_size_fuses));
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_app_pc_refused:
      assert property (pst.valid && {1'b0, pst.pc} < bstart |=> pst_refuse && !pst_accept)
      else $error("store from application code not refused");
   a_one_answer:
      assert property (pst.valid |=> pst_accept != pst_refuse) else $error("bad store answer");
   a_none_refused:
      assert property (pst.valid && pst.op == SFSG_OP_NONE |=> pst_refuse) else $error("op none");
   a_halt_stalls:
      assert property (flash_start && flash_op != SFSG_OP_LOAD && flash_target >= HALT_START
         |-> cpu_stall) else $error("halting page op without stall");
   a_conc_runs:
      assert property (flash_start && flash_target < HALT_START |-> !cpu_stall)
      else $error("concurrent page op stalls");
   a_stall_until_done:
      assert property (cpu_stall && !flash_done |=> cpu_stall) else $error("stall dropped early");
   a_stall_end_cause:
      assert property ($fell(cpu_stall) |-> $past(flash_done)) else $error("stall end w/o done");
   a_busy_refused:
      assert property (cpu_stall && pst.valid |=> pst_refuse) else $error("store taken in stall");
   a_conc_blocked:
      assert property (pst_accept && flash_op != SFSG_OP_LOAD && exec_pc < HALT_START
         |-> fetch_block) else $error("concurrent fetch not blocked");
   a_block_conc_only:
      assert property (fetch_block |-> exec_pc < HALT_START) else $error("halting fetch blocked");
   a_stall_no_read:
      assert property (cpu_stall |-> !lpm_allow) else $error("load allowed during stall");
   c_accept: cover property (pst_accept);
   c_stall: cover property ($rose(cpu_stall));
   c_block: cover property (fetch_block);
endmodule : sfsg_guard_chk

bind sfsg_guard sfsg_guard_chk #(.HALT_START(HALT_START), .BOOT_MIN_WORDS(BOOT_MIN_WORDS)) chk (
   .pclk(pclk), .presetn(presetn), .boot_size_fuses(boot_size_fuses), .pst(pst),
   .pst_accept(pst_accept), .pst_refuse(pst_refuse), .flash_start(flash_start),
   .flash_op(flash_op), .flash_target(flash_target), .flash_done(flash_done),
   .cpu_stall(cpu_stall), .exec_pc(exec_pc), .fetch_block(fetch_block), .lpm_allow(lpm_allow));

// >>> bench/sfsg_core_model.sv
// core-side model: reports erase or write completion after a fixed time
`timescale 1ns/1ns
module sfsg_core_model
   import sfsg_pkg::*;
#(
   parameter int DLY = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flash_start,
   input wire sfsg_op_e flash_op,
   output logic flash_done
);
   int cnt;
   // buffer loads finish at once, so only erase and write get a done pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         flash_done <= 1'b0;
      end else begin
         flash_done <= (cnt == 1);
         if (flash_start && flash_op != SFSG_OP_LOAD) cnt <= DLY;
         else if (cnt != 0) cnt <= cnt - 1;
      end
   end
endmodule : sfsg_core_model

// >>> bench/test_selfprog_flash_section_guard.sv
// self-checking bench of the section guard
`timescale 1ns/1ns
module test_selfprog_flash_section_guard
   import sfsg_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vib = 0, plw = 0, ce = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, er, acc, rfs, fs, stall, fblk, irqd, lpa, done;
   logic [1:0] fuse = 2'h3;
   logic [3:0] pld = 0;
   sfsg_pst_s pst = '0;
   sfsg_op_e fop;
   sfsg_addr_t ft, bs, xpc = 0, lpc = 0, lad = 0;
   int fail_count = 0, cmp_count = 0;
   always #10 pclk = ~pclk;
   sfsg_guard dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .boot_size_fuses(fuse), .vectors_in_boot(vib), .pst(pst),
      .pst_accept(acc), .pst_refuse(rfs), .flash_start(fs), .flash_op(fop),
      .flash_target(ft), .flash_done(done), .cpu_stall(stall), .exec_pc(xpc),
      .fetch_block(fblk), .irq_disable(irqd), .lpm_pc(lpc), .lpm_addr(lad),
      .lpm_allow(lpa), .prog_lock_we(plw), .prog_lock_data(pld), .chip_erase(ce));
   sfsg_core_model core (.pclk(pclk), .presetn(presetn), .flash_start(fs), .flash_op(fop),
      .flash_done(done));
   // ==========================================================
   // tasks
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task pst_go(input sfsg_op_e op, input sfsg_addr_t pc, input sfsg_addr_t t, input logic a);
      @(posedge pclk);
      pst <= {1'b1, op, pc, t};
      @(posedge pclk);
      pst.valid <= 1'b0;
      #1 chk({acc, rfs}, {a, !a});
   endtask : pst_go
   task wait_flash;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      #1;
   endtask : wait_flash
   task wrap_up;
      $display("checks %0d failures %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // ==========================================================
   // tests
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      apb(0, 12'h004, 0); chk(rd, 32'h0000000F);
      apb(0, 12'h00C, 0); chk({rd[30:0], er}, 32'h00000001);
      for (int f = 0; f < 4; f++) begin
         fuse <= f[1:0];
         bs = 13'h0000 - (13'h0080 << (3 - f));
         apb(0, 12'h008, 0); chk(rd, {3'h0, bs, 14'h0, f[1:0]});
      end
      fuse <= 2'h3;
      pst_go(SFSG_OP_ERASE, 13'h0100, 13'h0040, 0);
      pst_go(SFSG_OP_NONE, 13'h1F80, 13'h0040, 0);
      xpc <= 13'h0100; lpc <= 13'h1F80; lad <= 13'h0040;
      pst_go(SFSG_OP_ERASE, 13'h1F80, 13'h0040, 1);
      chk(stall, 0); chk(fblk, 1); chk(lpa, 0);
      chk(ft, 13'h0040); chk(fop, SFSG_OP_ERASE);
      apb(0, 12'h000, 0); chk(rd[0], 1);
      wait_flash;
      apb(1, 12'h000, 1); apb(0, 12'h000, 0); chk(rd[2:0], 0);
      pst_go(SFSG_OP_WRITE, 13'h1F80, 13'h0040, 1);
      wait_flash;
      pst_go(SFSG_OP_LOAD, 13'h1F80, 13'h0040, 1);
      apb(0, 12'h000, 0); chk(rd[0], 0);
      xpc <= 13'h1F90;
      pst_go(SFSG_OP_WRITE, 13'h1F80, 13'h1FC0, 1);
      chk(stall, 1); chk(ft, 13'h1FC0);
      pst_go(SFSG_OP_ERASE, 13'h1F80, 13'h0040, 0); chk(lpa, 0);
      wait_flash; chk(stall, 0);
      apb(1, 12'h000, 1); apb(1, 12'h004, 32'hE); lad <= 13'h0100;
      pst_go(SFSG_OP_ERASE, 13'h1F80, 13'h0100, 0); chk(lpa, 1);
      apb(1, 12'h004, 32'hC); vib <= 1; xpc <= 13'h0100;
      apb(0, 12'h004, 0); chk(rd, 32'hC); chk(lpa, 0); chk(irqd, 1);
      apb(1, 12'h004, 32'h8);
      pst_go(SFSG_OP_ERASE, 13'h1F80, 13'h1FC0, 0);
      apb(1, 12'h004, 32'h0); vib <= 0; xpc <= 13'h1F90; lpc <= 13'h0100; lad <= 13'h1FC0;
      apb(0, 12'h004, 0); chk(lpa, 0); chk(irqd, 1);
      apb(1, 12'h004, 32'hF); apb(0, 12'h004, 0); chk(rd, 0);
      // the pin inputs are filtered, so each pin level is held for several cycles
      @(posedge pclk) ce <= 1;
      repeat (6) @(posedge pclk);
      ce <= 0;
      apb(0, 12'h004, 0); chk(rd, 32'hF);
      plw <= 1; pld <= 4'hB;
      repeat (6) @(posedge pclk);
      plw <= 0;
      apb(0, 12'h004, 0); chk(rd, 32'hB);
      wrap_up;
   end
   // the tests take under 200 cycles, so this limit is generous
   initial begin
      #100000;
      fail_count++;
      wrap_up;
   end
endmodule : test_selfprog_flash_section_guard
